// ---- verilog/incdec_map.vh ----
// constants shared by the execution block and its helper modules
`ifndef INCDEC_MAP_VH
`define INCDEC_MAP_VH

// **********************************************************************
// operation select codes
// **********************************************************************
`define OP_WIDTH 3
`define OP_NOP 3'h0
`define OP_DEC_SKIP 3'h1
`define OP_INC_SKIP 3'h2
`define OP_JUMP 3'h3
`define OP_OR_LIT 3'h4
`define OP_INC 3'h5

// **********************************************************************
// operand layout
// **********************************************************************
`define DATA_WIDTH 8
`define FILE_ADDR_WIDTH 7
`define JUMP_LIT_WIDTH 11
`define OR_LIT_MSB 7
`define PC_WIDTH 13
`define PC_LOW_MSB 10
`define PAGE_SEL_MSB 4
`define PAGE_SEL_LSB 3
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1

// **********************************************************************
// reset values and step constants
// **********************************************************************
`define PC_RESET 13'h0000
`define PC_STEP 13'h0001
`define ACC_RESET 8'h00
`define DATA_ZERO 8'h00
`define DATA_ONE 8'h01
`define FILE_ADDR_RESET 7'h00
`define ZERO_FLAG_RESET 1'b0
`define CYCLES_ONE 2'h1
`define CYCLES_TWO 2'h2
`define CYCLES_RESET 2'h0

`endif

// ---- verilog/step_unit.v ----
// add or subtract one on a file register operand and flag a zero result
`timescale 1ns/10ps
`include "incdec_map.vh"

module step_unit (
   operand,
   decrement,
   result,
   is_zero
);
   input wire [`DATA_WIDTH-1:0] operand;
   input wire decrement;
   output wire [`DATA_WIDTH-1:0] result;
   output wire is_zero;

   // wraps modulo 256, so 00 - 1 gives ff and ff + 1 gives 00
   assign result = decrement ? (operand - `DATA_ONE) : (operand + `DATA_ONE);
   assign is_zero = (result == `DATA_ZERO);
endmodule // step_unit

// ---- verilog/jump_target.v ----
// build the full jump address from the literal and the page latch
`timescale 1ns/10ps
`include "incdec_map.vh"

module jump_target (
   literal,
   program_page_latch,
   target
);
   input wire [`JUMP_LIT_WIDTH-1:0] literal;
   input wire [`DATA_WIDTH-1:0] program_page_latch;
   output wire [`PC_WIDTH-1:0] target;

   assign target = {program_page_latch[`PAGE_SEL_MSB:`PAGE_SEL_LSB],
                    literal[`PC_LOW_MSB:0]};
endmodule // jump_target

// ---- verilog/incdec_skip_branch_or_exec.v ----
// execution logic for the step, skip, jump and or-literal instructions
//
// Overview of operation
// - decrement-skip subtracts one from file register, result to accumulator or file.
// - decrement-skip zero result discards next instruction as a nop; zero flag kept.
// - increment-skip adds one, writes by destination bit, leaves status flags alone.
// - increment-skip zero result replaces next instruction with nop, two cycles.
// - jump loads its eleven-bit literal into program counter bits 10..0.
// - jump takes program counter bits 12..11 from page latch bits 4..3.
// - jump takes two instruction cycles.
// - or-literal ors accumulator with eight-bit literal into accumulator, updates zero.
// - plain increment adds one, writes by destination bit, updates zero flag.
// - step instructions carry a seven-bit file address and a destination bit.
// - zero flag sets on an all-zero result of an affecting instruction, else clears.
`timescale 1ns/10ps
`include "incdec_map.vh"

module incdec_skip_branch_or_exec (
   clk,
   resetn,
   instr_valid,
   instr_ready,
   instr_op,
   file_addr,
   dest_sel,
   literal,
   file_operand,
   program_page_latch,
   file_wr_en,
   file_wr_addr,
   file_wr_data,
   accumulator,
   zero_flag,
   program_counter,
   discard_slot,
   retire,
   retire_cycles
);
   input wire clk;
   input wire resetn;
   input wire instr_valid;
   output wire instr_ready;
   input wire [`OP_WIDTH-1:0] instr_op;
   input wire [`FILE_ADDR_WIDTH-1:0] file_addr;
   input wire dest_sel;
   input wire [`JUMP_LIT_WIDTH-1:0] literal;
   input wire [`DATA_WIDTH-1:0] file_operand;
   input wire [`DATA_WIDTH-1:0] program_page_latch;
   output reg file_wr_en;
   output reg [`FILE_ADDR_WIDTH-1:0] file_wr_addr;
   output reg [`DATA_WIDTH-1:0] file_wr_data;
   output reg [`DATA_WIDTH-1:0] accumulator;
   output reg zero_flag;
   output reg [`PC_WIDTH-1:0] program_counter;
   output wire discard_slot;
   output reg retire;
   output reg [1:0] retire_cycles;

   // **********************************************************************
   // sequencer states
   // **********************************************************************
   localparam st_exec = 1'b0;
   localparam st_discard = 1'b1;

   reg state;
   reg next_state;
   reg [1:0] pending_cycles;
   reg [1:0] next_pending_cycles;

   // **********************************************************************
   // operand arithmetic
   // **********************************************************************
   wire [`DATA_WIDTH-1:0] dec_result;
   wire dec_zero;
   wire [`DATA_WIDTH-1:0] inc_result;
   wire inc_zero;
   wire [`PC_WIDTH-1:0] jump_addr;
   wire [`DATA_WIDTH-1:0] or_result;
   wire or_zero;

   step_unit u_dec (
      .operand(file_operand),
      .decrement(1'b1),
      .result(dec_result),
      .is_zero(dec_zero)
   );

   step_unit u_inc (
      .operand(file_operand),
      .decrement(1'b0),
      .result(inc_result),
      .is_zero(inc_zero)
   );

   jump_target u_jump (
      .literal(literal),
      .program_page_latch(program_page_latch),
      .target(jump_addr)
   );

   // only the low eight literal bits take part in the or
   assign or_result = accumulator | literal[`OR_LIT_MSB:0];
   assign or_zero = (or_result == `DATA_ZERO);

   // **********************************************************************
   // handshake
   // **********************************************************************
   // the word offered in the discard cycle is consumed and dropped, so the
   // fetch side must not hold it back for re-issue
   assign instr_ready = 1'b1;
   assign discard_slot = (state == st_discard);

   wire take = instr_valid && (state == st_exec);

   // **********************************************************************
   // operation decode
   // **********************************************************************
   reg is_dec_skip;
   reg is_inc_skip;
   reg is_jump;
   reg is_or_lit;
   reg is_inc;

   always @* begin
      is_dec_skip = 1'b0;
      is_inc_skip = 1'b0;
      is_jump = 1'b0;
      is_or_lit = 1'b0;
      is_inc = 1'b0;
      case (instr_op)
         `OP_DEC_SKIP: begin
            is_dec_skip = 1'b1;
         end
         `OP_INC_SKIP: begin
            is_inc_skip = 1'b1;
         end
         `OP_JUMP: begin
            is_jump = 1'b1;
         end
         `OP_OR_LIT: begin
            is_or_lit = 1'b1;
         end
         `OP_INC: begin
            is_inc = 1'b1;
         end
         default: begin
            // plain nop and the unused codes only advance the counter
         end
      endcase
   end

   // strobes are gated by take, so a word offered in the discard cycle can
   // never reach a register
   wire do_dec_skip = take && is_dec_skip;
   wire do_inc_skip = take && is_inc_skip;
   wire do_jump = take && is_jump;
   wire do_or_lit = take && is_or_lit;
   wire do_inc = take && is_inc;

   // a step result goes either to the file port or to the accumulator
   wire step_write = do_dec_skip || do_inc_skip || do_inc;
   wire [`DATA_WIDTH-1:0] step_value = do_dec_skip ? dec_result : inc_result;
   wire to_file = step_write && (dest_sel == `DEST_FILE);
   wire to_acc = step_write && (dest_sel == `DEST_ACC);

   // any nonzero result, not only one, lets the next word execute
   wire skip_next = (do_dec_skip && dec_zero) || (do_inc_skip && inc_zero);
   // the word prefetched behind a jump is flushed the same way
   wire two_cycle = skip_next || do_jump;

   // **********************************************************************
   // sequencer next values
   // **********************************************************************
   reg [`PC_WIDTH-1:0] next_program_counter;
   reg next_retire;
   reg [1:0] next_retire_cycles;

   always @* begin
      next_state = state;
      next_pending_cycles = pending_cycles;
      case (state)
         st_exec: begin
            if (two_cycle) begin
               next_state = st_discard;
               next_pending_cycles = `CYCLES_TWO;
            end
         end
         st_discard: begin
            // exactly one cycle, whatever is offered meanwhile
            next_state = st_exec;
            next_pending_cycles = `CYCLES_RESET;
         end
         default: begin
            next_state = st_exec;
            next_pending_cycles = `CYCLES_RESET;
         end
      endcase
   end

   // the discard cycle still costs a program counter step
   always @* begin
      next_program_counter = program_counter;
      if (do_jump) begin
         next_program_counter = jump_addr;
      end else if (take || discard_slot) begin
         next_program_counter = program_counter + `PC_STEP;
      end
   end

   // a two-cycle instruction retires only after its discard cycle
   always @* begin
      next_retire = 1'b0;
      next_retire_cycles = retire_cycles;
      if (discard_slot) begin
         next_retire = 1'b1;
         next_retire_cycles = pending_cycles;
      end else if (take) begin
         next_retire = !two_cycle;
         next_retire_cycles = `CYCLES_ONE;
      end
   end

   // **********************************************************************
   // datapath next values
   // **********************************************************************
   reg next_file_wr_en;
   reg [`DATA_WIDTH-1:0] next_file_wr_data;
   reg [`DATA_WIDTH-1:0] next_accumulator;
   reg next_zero_flag;

   always @* begin
      next_file_wr_en = 1'b0;
      next_file_wr_data = file_wr_data;
      next_accumulator = accumulator;
      next_zero_flag = zero_flag;
      if (to_file) begin
         next_file_wr_en = 1'b1;
         next_file_wr_data = step_value;
      end
      if (to_acc) begin
         next_accumulator = step_value;
      end
      if (do_or_lit) begin
         next_accumulator = or_result;
         next_zero_flag = or_zero;
      end
      // the skip instructions deliberately leave the zero flag as it was
      if (do_inc) begin
         next_zero_flag = inc_zero;
      end
   end

   // **********************************************************************
   // sequencer registers
   // **********************************************************************
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= st_exec;
         pending_cycles <= `CYCLES_RESET;
         program_counter <= `PC_RESET;
         retire <= 1'b0;
         retire_cycles <= `CYCLES_RESET;
      end else begin
         state <= next_state;
         pending_cycles <= next_pending_cycles;
         program_counter <= next_program_counter;
         retire <= next_retire;
         retire_cycles <= next_retire_cycles;
      end
   end

   // **********************************************************************
   // working register and zero flag
   // **********************************************************************
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         accumulator <= `ACC_RESET;
         zero_flag <= `ZERO_FLAG_RESET;
      end else begin
         accumulator <= next_accumulator;
         zero_flag <= next_zero_flag;
      end
   end

   // **********************************************************************
   // file register write port
   // **********************************************************************
   // the address loads only with a write, so an idle port keeps naming the
   // register written last
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         file_wr_en <= 1'b0;
         file_wr_addr <= `FILE_ADDR_RESET;
         file_wr_data <= `DATA_ZERO;
      end else begin
         file_wr_en <= next_file_wr_en;
         if (next_file_wr_en) begin
            file_wr_addr <= file_addr;
         end
         file_wr_data <= next_file_wr_data;
      end
   end
endmodule // incdec_skip_branch_or_exec

// ---- tb/incdec_checker.sv ----
// concurrent checks on the ports of the step, skip, jump and or-literal block
`timescale 1ns/10ps
`include "incdec_map.vh"

module incdec_checker (
   input wire clk,
   input wire resetn,
   input wire instr_valid,
   input wire [`OP_WIDTH-1:0] instr_op,
   input wire [`FILE_ADDR_WIDTH-1:0] file_addr,
   input wire dest_sel,
   input wire [`JUMP_LIT_WIDTH-1:0] literal,
   input wire [`DATA_WIDTH-1:0] file_operand,
   input wire [`DATA_WIDTH-1:0] program_page_latch,
   input wire file_wr_en,
   input wire [`FILE_ADDR_WIDTH-1:0] file_wr_addr,
   input wire [`DATA_WIDTH-1:0] file_wr_data,
   input wire [`DATA_WIDTH-1:0] accumulator,
   input wire zero_flag,
   input wire [`PC_WIDTH-1:0] program_counter,
   input wire discard_slot,
   input wire retire,
   input wire [1:0] retire_cycles
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   wire take = instr_valid && !discard_slot;
   wire dec_t = take && instr_op == `OP_DEC_SKIP;
   wire inc_t = take && instr_op == `OP_INC_SKIP;
   // ************************************************************
   // two-cycle completion: discard slot, then a retire worth two
   // ************************************************************
   sequence s_two_cycle;
      discard_slot ##1 (retire && retire_cycles == `CYCLES_TWO && !discard_slot);
   endsequence
   sequence s_one_cycle;
      !discard_slot && retire && retire_cycles == `CYCLES_ONE;
   endsequence
   a_dec_zero_skip: assert property (dec_t && file_operand == `DATA_ONE |=> s_two_cycle)
      else $error("decrement to zero did not skip");
   a_inc_zero_skip: assert property (inc_t && file_operand == 8'hff |=> s_two_cycle)
      else $error("increment to zero did not skip");
   a_nonzero_no_skip: assert property ((dec_t && file_operand != `DATA_ONE) ||
      (inc_t && file_operand != 8'hff) |=> s_one_cycle) else $error("nonzero result skipped");
   a_jump_target_pc: assert property (take && instr_op == `OP_JUMP |=>
      program_counter == {$past(program_page_latch[4:3]), $past(literal)})
      else $error("jump target wrong");
   a_jump_two_cycles: assert property (take && instr_op == `OP_JUMP |=> s_two_cycle)
      else $error("jump did not take two cycles");
   a_skip_zero_kept: assert property (dec_t || inc_t |=> $stable(zero_flag))
      else $error("skip changed zero flag");
   a_dec_file_write: assert property (dec_t && dest_sel |=> file_wr_en &&
      file_wr_data == $past(file_operand) - `DATA_ONE && file_wr_addr == $past(file_addr))
      else $error("decrement write wrong");
   a_incskip_file_write: assert property (inc_t && dest_sel |=> file_wr_en &&
      file_wr_data == $past(file_operand) + `DATA_ONE) else $error("increment write wrong");
   a_inc_to_acc: assert property (take && instr_op == `OP_INC && !dest_sel |=>
      !file_wr_en && accumulator == $past(file_operand) + `DATA_ONE &&
      zero_flag == (accumulator == `DATA_ZERO)) else $error("increment to accumulator wrong");
   a_or_literal: assert property (take && instr_op == `OP_OR_LIT |=>
      accumulator == ($past(accumulator) | $past(literal[7:0])) &&
      zero_flag == (accumulator == `DATA_ZERO)) else $error("or literal wrong");
   a_discard_one: assert property (discard_slot |=> !discard_slot && !file_wr_en)
      else $error("discard slot overran");
endmodule // incdec_checker

bind incdec_skip_branch_or_exec incdec_checker u_incdec_checker (.clk(clk), .resetn(resetn),
   .instr_valid(instr_valid), .instr_op(instr_op), .file_addr(file_addr),
   .dest_sel(dest_sel), .literal(literal), .file_operand(file_operand),
   .program_page_latch(program_page_latch), .file_wr_en(file_wr_en),
   .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .accumulator(accumulator),
   .zero_flag(zero_flag), .program_counter(program_counter), .discard_slot(discard_slot),
   .retire(retire), .retire_cycles(retire_cycles));

// ---- tb/incdec_skip_branch_or_exec_bench.sv ----
// self-checking bench for the step, skip, jump and or-literal block
`timescale 1ns/10ps
`include "incdec_map.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

module incdec_skip_branch_or_exec_bench;
   reg clk = 1'b0;
   reg resetn = 1'b0;
   reg instr_valid = 1'b0;
   reg [2:0] instr_op = 3'h0;
   reg [6:0] file_addr = 7'h00;
   reg dest_sel = 1'b0;
   reg [10:0] literal = 11'h000;
   reg [7:0] file_operand = 8'h00;
   reg [7:0] program_page_latch = 8'h00;
   wire file_wr_en, zero_flag, discard_slot, retire, instr_ready;
   wire [6:0] file_wr_addr;
   wire [7:0] file_wr_data, accumulator;
   wire [12:0] program_counter;
   wire [1:0] retire_cycles;
   reg [7:0] m_acc = 8'h00, m_wd = 8'h00, v;
   reg [6:0] m_wa = 7'h00;
   reg [12:0] m_pc = 13'h0000;
   reg m_zf = 1'b0;
   logic [38:0] q[$];
   wire [38:0] observed = {accumulator, zero_flag, retire_cycles, program_counter, file_wr_addr,
      file_wr_data};
   integer seed = 98415;
   int mismatches = 0, num_checks = 0;

   incdec_skip_branch_or_exec u_incdec_skip_branch_or_exec (.clk(clk), .resetn(resetn),
      .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_op(instr_op),
      .file_addr(file_addr),
      .dest_sel(dest_sel), .literal(literal), .file_operand(file_operand),
      .program_page_latch(program_page_latch), .file_wr_en(file_wr_en),
      .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .accumulator(accumulator),
      .zero_flag(zero_flag), .program_counter(program_counter), .discard_slot(discard_slot),
      .retire(retire), .retire_cycles(retire_cycles));

   always #5 clk = ~clk;

   // ************************************************************
   // issue one instruction and note the state expected at retire
   // ************************************************************
   task run_op(input [2:0] op, input [7:0] opnd);
      reg [31:0] r;
      reg [7:0] res;
      reg two;
      begin
         r = $random(seed);
         r[15:8] = r[15:8] & opnd; // a zero operand also forces the low eight literal bits to zero
         two = 1'b0;
         instr_valid <= 1'b1;
         instr_op <= op;
         file_addr <= r[6:0];
         dest_sel <= r[7];
         literal <= r[18:8];
         file_operand <= opnd;
         program_page_latch <= r[26:19];
         case (op)
            `OP_DEC_SKIP, `OP_INC_SKIP, `OP_INC: begin
               res = (op == `OP_DEC_SKIP) ? opnd - 8'h01 : opnd + 8'h01;
               if (r[7]) begin
                  m_wa = r[6:0];
                  m_wd = res;
               end else
                  m_acc = res;
               if (op == `OP_INC) m_zf = (res == 8'h00);
               else two = (res == 8'h00);
            end
            `OP_JUMP: two = 1'b1;
            `OP_OR_LIT: begin
               m_acc = m_acc | r[15:8];
               m_zf = (m_acc == 8'h00);
            end
         endcase
         if (op == `OP_JUMP) m_pc = {r[23:22], r[18:8]} + 13'h0001;
         else m_pc = m_pc + (two ? 13'h0002 : 13'h0001);
         q.push_back({m_acc, m_zf, two ? 2'h2 : 2'h1, m_pc, m_wa, m_wd});
         @(posedge clk);
         if (two) begin
            // a live word in the discard slot must be dropped
            instr_op <= r[30:28];
            file_operand <= ~opnd;
            @(posedge clk);
         end
      end
   endtask

   task print_verdict;
      begin
         if (mismatches == 0 && num_checks > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask

   // the oldest note is read in place and dropped afterwards, so a mismatch
   // cannot pop a second note while it prints the expected value
   always @(posedge clk)
      if (retire === 1'b1) begin
         `CHK(observed, q[0])
         q.delete(0);
      end

   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      run_op(`OP_OR_LIT, 8'h00);
      run_op(`OP_DEC_SKIP, 8'h01);
      run_op(`OP_INC_SKIP, 8'hff);
      run_op(`OP_DEC_SKIP, 8'h00);
      run_op(`OP_INC, 8'hff);
      run_op(`OP_JUMP, 8'hff);
      run_op(`OP_JUMP, 8'hff);
      run_op(`OP_NOP, 8'h3c);
      run_op(3'h7, 8'h00);
      repeat (400) begin
         v = 8'($random(seed));
         run_op(3'h1 + 3'($unsigned($random(seed)) % 5), v[6] ? v : {{7{v[5]}}, v[4]});
      end
      instr_valid <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK(q.size(), 0)
      `CHK(instr_ready, 1'b1)
      print_verdict;
   end

   initial begin
      #20000;
      mismatches++;
      print_verdict;
   end
endmodule // incdec_skip_branch_or_exec_bench
